// ### hdl/rld_pkg.sv
// Shared constants and types for the repeater LED status display.
// Assumes a single 10 MHz clock with synchronous active-high reset.
package rld_pkg;
   localparam int NPORT = 5;
   localparam int NBAR = 8;
   localparam int CLK_NS = 100;
   localparam int CYC_PER_MS = 1000000 / CLK_NS;
   localparam int CYC_PER_US = 1000 / CLK_NS;

   // Printed times, in their own units.
   localparam int BLK130_MS = 130;
   localparam int BLK260_MS = 260;
   localparam int BLK512_MS = 512;
   localparam int BLK1560_MS = 1560;
   localparam int STRETCH_MS = 4;
   localparam int COL111_US = 100;
   localparam int WINDOW_MS = 250;
   localparam int HOLD_MS = 4000;
   localparam int MINPKT_BITS = 96;
   localparam int BIT_NS = 100;
   localparam int STARTUP_BLINKS = 16;

   // Cycle counts; blink counts are half periods.
   localparam int HALF130_CYC = BLK130_MS * CYC_PER_MS / 2;
   localparam int HALF260_CYC = BLK260_MS * CYC_PER_MS / 2;
   localparam int HALF512_CYC = BLK512_MS * CYC_PER_MS / 2;
   localparam int HALF1560_CYC = BLK1560_MS * CYC_PER_MS / 2;
   localparam int STRETCH_CYC = STRETCH_MS * CYC_PER_MS;
   localparam int COL111_CYC = COL111_US * CYC_PER_US;
   localparam int WINDOW_CYC = WINDOW_MS * CYC_PER_MS;
   localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
   // Half the shortest packet, so that every packet spans a tick sample.
   localparam int TICK_CYC = MINPKT_BITS * BIT_NS / CLK_NS / 2;

   // Register map and fields.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam int CTRL_RATE_LSB = 0;
   localparam int CTRL_OVR_A_BIT = 2;
   localparam int CTRL_OVR_B_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int STAT_BAR_LSB = 0;
   localparam int STAT_LB_BIT = 8;
   localparam int STAT_BUSY_BIT = 9;
   localparam int STAT_SEL_LSB = 12;

   // Attribute selection codes.
   localparam logic [2:0] SEL_CRS_LINK = 3'h0;
   localparam logic [2:0] SEL_CRS_ALL = 3'h1;
   localparam logic [2:0] SEL_BLK260 = 3'h4;
   localparam logic [2:0] SEL_BLK512 = 3'h5;
   localparam logic [2:0] SEL_BLK130 = 3'h6;
   localparam logic [2:0] SEL_BLK1560 = 3'h7;

   localparam int UTIL_PCT [NBAR] = '{1, 2, 4, 8, 16, 32, 64, 80};

   typedef enum logic [1:0] {
      RATE_OFF, RATE_512, RATE_1560, RATE_SOLID
   } rld_rate_t;

   typedef struct packed {
      logic carrier_sense_attr;
      logic col;
      logic link;
      logic par;
      logic dis;
   } rld_port_attr_t;
endpackage

// ### hdl/rld_stretch.sv
// Pulse stretcher: output stays active len_i cycles after the trigger ends.
// Assumes the trigger is synchronous to clk_i.
`timescale 1ns/1ps
module rld_stretch #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic trig_i,
   input wire logic [W-1:0] len_i,
   output logic active_o
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if (trig_i) begin
         cnt_r <= len_i;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign active_o = trig_i | (cnt_r != '0);
endmodule

// ### hdl/rld_util_meter.sv
// Network utilization meter driving an eight-step bar graph.
// Assumes transmit activity is a level synchronous to clk_i.
`timescale 1ns/1ps
module rld_util_meter #(
   parameter int TICK_CYC = rld_pkg::TICK_CYC,
   parameter int WINDOW_CYC = rld_pkg::WINDOW_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic act_i,
   output logic [rld_pkg::NBAR-1:0] bar_o
);
   localparam int MAXEV = WINDOW_CYC / TICK_CYC;
   logic [31:0] tick_r;
   logic [31:0] win_r;
   logic [31:0] ev_r;
   logic tick;
   logic win_end;

   assign tick = (tick_r == 32'(TICK_CYC - 1));
   assign win_end = (win_r == 32'(WINDOW_CYC - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || tick) begin
         tick_r <= '0;
      end else begin
         tick_r <= tick_r + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || win_end) begin
         win_r <= '0;
      end else begin
         win_r <= win_r + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || win_end) begin
         ev_r <= '0;
      end else if (tick && act_i) begin
         ev_r <= ev_r + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bar_o <= '0;
      end else if (win_end) begin
         for (int i = 0; i < rld_pkg::NBAR; i++) begin
            bar_o[i] <= ev_r > 32'(MAXEV * rld_pkg::UTIL_PCT[i] / 100);
         end
      end
   end

   a_bar_thermo: assert property (@(posedge clk_i) disable iff (rst_i)
      ((bar_o & (bar_o + 8'h01)) == 8'h00))
      else $error("Bar graph is not a thermometer code.");
   a_bar_window: assert property (@(posedge clk_i) disable iff (rst_i)
      !win_end |=> $stable(bar_o))
      else $error("Bar graph changed outside a window end.");
   c_bar_full: cover property (@(posedge clk_i) bar_o == 8'hFF);
endmodule

// ### hdl/rld_top.sv
// Repeater LED status display: port and global indicators, software
// override, and the utilization bar graph, with a Wishbone slave.
// Assumes all inputs are synchronous to clk_i; the select pins are steady.
// Function
// - Twelve indicators, select code chooses attributes.
// - Indicator either released or pulled low.
// - Blinking attribute wins over solid one.
// - Attribute without blink shown solidly lit.
// - Code 110: link solid, activity 130ms blink.
// - Code 000: partition turns link indicator off.
// - Code 101: sixteen 260ms blinks after reset.
// - Code 111: all on four seconds after reset.
// - Bank override drives whole bank low.
// - Override ignores the selected attributes.
// - Override rate: off, 512ms, 1560ms, solid.
// - Override uses the latest blink rate.
// - Carrier indication stretched at least 4ms.
// - Collision stretched 4ms, or 100us under 111.
// - Codes 000, 001 show loopback on AUI.
// - Loopback true only after good loopback.
// - Loopback sampled at packet end, then latched.
// - Loopback false after reset.
// - Utilization outputs form a bar graph.
// - Thresholds 1% up to 80% per step.
// - Utilization updated every 250ms window.
// - Count active ticks fine enough for 96 bits.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module rld_top #(
   parameter int HALF130_CYC = rld_pkg::HALF130_CYC,
   parameter int HALF260_CYC = rld_pkg::HALF260_CYC,
   parameter int HALF512_CYC = rld_pkg::HALF512_CYC,
   parameter int HALF1560_CYC = rld_pkg::HALF1560_CYC,
   parameter int STRETCH_CYC = rld_pkg::STRETCH_CYC,
   parameter int WINDOW_CYC = rld_pkg::WINDOW_CYC,
   parameter int HOLD_CYC = rld_pkg::HOLD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] led_attribute_select_i,
   input wire rld_pkg::rld_port_attr_t [rld_pkg::NPORT-1:0] port_attr_i,
   input wire logic jabber_attr_i,
   input wire logic repeater_tx_act_i,
   input wire logic aui_tx_crs_i,
   input wire logic aui_loop_seen_i,
   input wire logic aui_loop_err_i,
   input wire logic aui_reverse_i,
   output logic [rld_pkg::NPORT-1:0] bank_a_port_led_o,
   output logic [rld_pkg::NPORT-1:0] bank_a_port_led_oe_o,
   output logic [rld_pkg::NPORT-1:0] bank_b_port_led_o,
   output logic [rld_pkg::NPORT-1:0] bank_b_port_led_oe_o,
   output logic bank_a_global_led_o,
   output logic bank_a_global_led_oe_o,
   output logic bank_b_global_led_o,
   output logic bank_b_global_led_oe_o,
   output logic [rld_pkg::NBAR-1:0] utilization_bar_led_o,
   output logic [rld_pkg::NBAR-1:0] utilization_bar_led_oe_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   localparam int NP = rld_pkg::NPORT;
   localparam int HALF_CYC [4] = '{HALF130_CYC, HALF260_CYC, HALF512_CYC,
                                   HALF1560_CYC};

   typedef enum logic [1:0] {ST_INIT, ST_BLINK, ST_HOLD, ST_RUN} rld_st_t;

   rld_st_t st_r;
   logic [3:0] ctrl_r;
   logic [3:0] phase_r;
   logic [31:0] blk_cnt_r [4];
   logic [5:0] start_blk_r;
   logic [31:0] hold_r;
   logic lb_r;
   logic tx_crs_d_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic [NP-1:0] a_oe_r;
   logic [NP-1:0] b_oe_r;
   logic ga_oe_r;
   logic gb_oe_r;
   logic [NP-1:0] crs_st;
   logic [NP-1:0] col_st;
   logic [NP-1:0] lit_a;
   logic [NP-1:0] lit_b;
   logic lit_ga;
   logic lit_gb;
   logic ovr_lit;
   logic pkt_end;
   logic wb_req;
   logic [15:0] col_len;
   logic [rld_pkg::NBAR-1:0] bar;
   logic [2:0] sel;
   rld_pkg::rld_rate_t rate;

   assign sel = led_attribute_select_i;
   assign rate = rld_pkg::rld_rate_t'(ctrl_r[rld_pkg::CTRL_RATE_LSB +: 2]);

   // Blink phases run free so all indicators of one rate stay in step.
   for (genvar k = 0; k < 4; k++) begin : g_blink
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            blk_cnt_r[k] <= '0;
            phase_r[k] <= 1'b0;
         end else if (blk_cnt_r[k] == 32'(HALF_CYC[k] - 1)) begin
            blk_cnt_r[k] <= '0;
            phase_r[k] <= ~phase_r[k];
         end else begin
            blk_cnt_r[k] <= blk_cnt_r[k] + 32'h1;
         end
      end
   end

   assign col_len = (sel == rld_pkg::SEL_BLK1560) ?
                    16'(rld_pkg::COL111_CYC) : 16'(STRETCH_CYC);

   // stretch carrier and collision per port
   for (genvar p = 0; p < NP; p++) begin : g_port
      rld_stretch #(
         .W(16)
      ) u_crs (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .trig_i(port_attr_i[p].carrier_sense_attr),
         .len_i(16'(STRETCH_CYC)),
         .active_o(crs_st[p])
      );
      rld_stretch #(
         .W(16)
      ) u_col (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .trig_i(port_attr_i[p].col),
         .len_i(col_len),
         .active_o(col_st[p])
      );
   end

   rld_util_meter #(
      .TICK_CYC(rld_pkg::TICK_CYC),
      .WINDOW_CYC(WINDOW_CYC)
   ) u_util (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .act_i(repeater_tx_act_i),
      .bar_o(bar)
   );

   // Power-up display sequence; the select code is read once after reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= ST_INIT;
      end else begin
         unique case (st_r)
            ST_INIT: begin
               if (sel == rld_pkg::SEL_BLK512) begin
                  st_r <= ST_BLINK;
               end else if (sel == rld_pkg::SEL_BLK1560) begin
                  st_r <= ST_HOLD;
               end else begin
                  st_r <= ST_RUN;
               end
            end
            ST_BLINK: begin
               if (start_blk_r == 6'(2 * rld_pkg::STARTUP_BLINKS)) begin
                  st_r <= ST_RUN;
               end
            end
            ST_HOLD: begin
               if (hold_r == 32'(HOLD_CYC - 1)) begin
                  st_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               st_r <= ST_RUN;
            end
         endcase
      end
   end

   // count 260ms half periods during the start blink
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_blk_r <= '0;
      end else if (st_r == ST_BLINK &&
                   blk_cnt_r[1] == 32'(HALF260_CYC - 1)) begin
         start_blk_r <= start_blk_r + 6'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_r <= '0;
      end else if (st_r == ST_HOLD) begin
         hold_r <= hold_r + 32'h1;
      end
   end

   // sample loopback at the end of each packet
   assign pkt_end = tx_crs_d_r & ~aui_tx_crs_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_crs_d_r <= 1'b0;
      end else begin
         tx_crs_d_r <= aui_tx_crs_i;
      end
   end

   // loopback false from reset, cleared if disabled or reversed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lb_r <= 1'b0;
      end else if (port_attr_i[0].dis || aui_reverse_i) begin
         lb_r <= 1'b0;
      end else if (pkt_end) begin
         lb_r <= aui_loop_seen_i & ~aui_loop_err_i;
      end
   end

   always_comb begin
      unique case (rate)
         rld_pkg::RATE_OFF: ovr_lit = 1'b0;
         rld_pkg::RATE_512: ovr_lit = phase_r[2];
         rld_pkg::RATE_1560: ovr_lit = phase_r[3];
         rld_pkg::RATE_SOLID: ovr_lit = 1'b1;
      endcase
   end

   always_comb begin
      lit_a = '0;
      lit_b = '0;
      lit_ga = |crs_st;
      lit_gb = |col_st;
      for (int i = 0; i < NP; i++) begin
         unique case (sel)
            rld_pkg::SEL_CRS_LINK: begin
               // partition hides link, loopback on AUI
               lit_a[i] = (i == 0) ? lb_r :
                          port_attr_i[i].link & ~port_attr_i[i].par;
               lit_b[i] = port_attr_i[i].par;
            end
            rld_pkg::SEL_CRS_ALL: begin
               lit_a[i] = (i == 0) ? lb_r : port_attr_i[i].link;
               lit_b[i] = crs_st[i];
            end
            rld_pkg::SEL_BLK260: begin
               // blink wins over the solid attribute
               lit_a[i] = crs_st[i] ? phase_r[1] :
                          (i != 0) && port_attr_i[i].link;
               lit_b[i] = col_st[i] ? phase_r[1] : port_attr_i[i].par;
            end
            rld_pkg::SEL_BLK512: begin
               lit_a[i] = crs_st[i] ? phase_r[2] :
                          (i != 0) && port_attr_i[i].link;
               lit_b[i] = crs_st[i] ? phase_r[2] : port_attr_i[i].par;
            end
            rld_pkg::SEL_BLK130: begin
               // activity blinks, link or partition solid
               lit_a[i] = crs_st[i] ? phase_r[0] : (i != 0) &&
                          (port_attr_i[i].link | port_attr_i[i].par);
               lit_b[i] = port_attr_i[i].par | port_attr_i[i].dis;
            end
            rld_pkg::SEL_BLK1560: begin
               lit_a[i] = port_attr_i[i].par ? phase_r[3] :
                          (i != 0) && port_attr_i[i].link;
               lit_b[i] = (i == 0) ? port_attr_i[i].par : col_st[i];
            end
            default: begin
               lit_a[i] = 1'b0;
               lit_b[i] = 1'b0;
            end
         endcase
      end
      unique case (sel)
         rld_pkg::SEL_BLK260: begin
            lit_ga = (|crs_st) & phase_r[1];
            lit_gb = (|col_st) & phase_r[1];
         end
         rld_pkg::SEL_BLK512: begin
            lit_ga = |col_st;
            lit_gb = jabber_attr_i;
         end
         3'h2, 3'h3: begin
            lit_ga = 1'b0;
            lit_gb = 1'b0;
         end
         default: begin
            lit_ga = |crs_st;
            lit_gb = |col_st;
         end
      endcase
   end

   // open-drain: enable asserted only when lit; released otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i || st_r == ST_INIT) begin
         a_oe_r <= '0;
         b_oe_r <= '0;
         ga_oe_r <= 1'b0;
         gb_oe_r <= 1'b0;
      end else begin
         a_oe_r <= lit_a;
         b_oe_r <= lit_b;
         ga_oe_r <= lit_ga;
         gb_oe_r <= lit_gb;
         if (st_r == ST_BLINK) begin
            // start blink, lit on the first half period
            a_oe_r <= {NP{~phase_r[1]}};
            b_oe_r <= {NP{~phase_r[1]}};
            ga_oe_r <= ~phase_r[1];
            gb_oe_r <= ~phase_r[1];
         end else if (st_r == ST_HOLD) begin
            a_oe_r <= '1;
            b_oe_r <= '1;
            ga_oe_r <= 1'b1;
            gb_oe_r <= 1'b1;
         end
         if (ctrl_r[rld_pkg::CTRL_OVR_A_BIT]) begin
            a_oe_r <= {NP{ovr_lit}};
            ga_oe_r <= ovr_lit;
         end
         if (ctrl_r[rld_pkg::CTRL_OVR_B_BIT]) begin
            b_oe_r <= {NP{ovr_lit}};
            gb_oe_r <= ovr_lit;
         end
      end
   end

   // twelve indicators plus the bar graph, all open drain
   assign bank_a_port_led_o = '0;
   assign bank_b_port_led_o = '0;
   assign bank_a_global_led_o = 1'b0;
   assign bank_b_global_led_o = 1'b0;
   assign utilization_bar_led_o = '0;
   assign bank_a_port_led_oe_o = a_oe_r;
   assign bank_b_port_led_oe_o = b_oe_r;
   assign bank_a_global_led_oe_o = ga_oe_r;
   assign bank_b_global_led_oe_o = gb_oe_r;
   assign utilization_bar_led_oe_o = bar;

   // Wishbone: one wait state, ack for any address, unmapped reads zero.
   assign wb_req = wb_cyc_i & wb_stb_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req & ~ack_r;
      end
   end

   // the latest written rate applies to every overridden bank
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= rld_pkg::CTRL_RST;
      end else if (ack_r && wb_req && wb_we_i && wb_sel_i[0] &&
                   wb_adr_i == rld_pkg::CTRL_OFS) begin
         ctrl_r <= wb_dat_i[3:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_r <= '0;
      end else begin
         rdat_r <= '0;
         if (wb_adr_i == rld_pkg::CTRL_OFS) begin
            rdat_r[3:0] <= ctrl_r;
         end else if (wb_adr_i == rld_pkg::STAT_OFS) begin
            rdat_r[rld_pkg::STAT_BAR_LSB +: rld_pkg::NBAR] <= bar;
            rdat_r[rld_pkg::STAT_LB_BIT] <= lb_r;
            rdat_r[rld_pkg::STAT_BUSY_BIT] <= (st_r != ST_RUN);
            rdat_r[rld_pkg::STAT_SEL_LSB +: 3] <= sel;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   a_ovr_solid: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_r[rld_pkg::CTRL_OVR_A_BIT] && rate == rld_pkg::RATE_SOLID
      && st_r != ST_INIT |=> a_oe_r == 5'h1F && ga_oe_r)
      else $error("Bank A override solid did not light the bank.");
   a_ovr_rate_off: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_r[rld_pkg::CTRL_OVR_B_BIT] && rate == rld_pkg::RATE_OFF
      |=> b_oe_r == 5'h00 && !gb_oe_r)
      else $error("Bank B override off left an indicator lit.");
   a_reserved_dark: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r == ST_RUN && ctrl_r[3:2] == 2'h0 && sel[2:1] == 2'h1
      |=> a_oe_r == 5'h00 && b_oe_r == 5'h00 && !ga_oe_r)
      else $error("Reserved select code lit an indicator.");
   a_part_link_off: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r == ST_RUN && !ctrl_r[2] && sel == rld_pkg::SEL_CRS_LINK
      && port_attr_i[1].par |=> !a_oe_r[1])
      else $error("Partitioned port showed its link indicator.");
   a_act_blink130: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r == ST_RUN && !ctrl_r[2] && sel == rld_pkg::SEL_BLK130
      && crs_st[3] |=> a_oe_r[3] == $past(phase_r[0]))
      else $error("Activity did not follow the 130ms blink.");
   a_hold_all_on: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r == ST_HOLD && ctrl_r[3:2] == 2'h0
      |=> b_oe_r == 5'h1F && gb_oe_r)
      else $error("Indicators not all lit during the hold.");
   a_lb_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
      port_attr_i[0].dis || aui_reverse_i |=> !lb_r)
      else $error("Loopback true while AUI disabled or reversed.");
   a_lb_latched: assert property (@(posedge clk_i) disable iff (rst_i)
      !pkt_end |=> lb_r == $past(lb_r) || !lb_r)
      else $error("Loopback set outside a packet end.");
   a_lb_reset: assert property (@(posedge clk_i)
      rst_i |=> !lb_r)
      else $error("Loopback not false after reset.");
   a_crs_stretch: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(port_attr_i[3].carrier_sense_attr) |-> crs_st[3] [*8])
      else $error("Carrier indication dropped too soon.");

   c_ovr_used: cover property (@(posedge clk_i)
      ctrl_r[rld_pkg::CTRL_OVR_A_BIT] && ctrl_r[rld_pkg::CTRL_OVR_B_BIT]);
   c_start_blink_done: cover property (@(posedge clk_i)
      st_r == ST_BLINK ##1 st_r == ST_RUN);
   c_lb_set: cover property (@(posedge clk_i) $rose(lb_r));
endmodule

// ### tb/rld_led_model.sv
// Indicator diodes hung on the open-drain pins, each with its own pull-up.
// Assumes an enable that is high means the pin sinks current.
`timescale 1ns/1ps
module rld_led_model (
   input wire logic [19:0] oe_i,
   input wire logic [19:0] dat_i,
   output logic [19:0] lit_o
);
   logic [19:0] pin;
   assign pin = (oe_i & dat_i) | ~oe_i;
   assign lit_o = ~pin;
endmodule

// ### tb/test_repeater_led_status_display.sv
// Self-checking bench for the indicator block with shortened periods.
// Assumes the lit vector: [4:0] A, [9:5] B, [10] A global, [11] B global.
`timescale 1ns/1ps
module test_repeater_led_status_display;
   localparam int WIN = 4800;
   localparam int STR = 20;
   logic clk_i, rst_i, jabber_attr, act, tcrs, seen, err, rev, cyc, stb, we, ack;
   logic [2:0] sel;
   logic [3:0] be;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, rd, r;
   logic [19:0] oe, dat, lit;
   rld_pkg::rld_port_attr_t [rld_pkg::NPORT-1:0] pa;
   int bad_count, checks, seed, c;
   rld_top #(.HALF130_CYC(4), .HALF260_CYC(8), .HALF512_CYC(16),
      .HALF1560_CYC(48), .STRETCH_CYC(STR), .WINDOW_CYC(WIN),
      .HOLD_CYC(100)) i_dut (.clk_i, .rst_i,
      .led_attribute_select_i(sel), .port_attr_i(pa), .jabber_attr_i(jabber_attr),
      .repeater_tx_act_i(act), .aui_tx_crs_i(tcrs), .aui_loop_seen_i(seen),
      .aui_loop_err_i(err), .aui_reverse_i(rev),
      .bank_a_port_led_o(dat[4:0]), .bank_a_port_led_oe_o(oe[4:0]),
      .bank_b_port_led_o(dat[9:5]), .bank_b_port_led_oe_o(oe[9:5]),
      .bank_a_global_led_o(dat[10]), .bank_a_global_led_oe_o(oe[10]),
      .bank_b_global_led_o(dat[11]), .bank_b_global_led_oe_o(oe[11]),
      .utilization_bar_led_o(dat[19:12]),
      .utilization_bar_led_oe_o(oe[19:12]), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack));
   rld_led_model i_led (.oe_i(oe), .dat_i(dat), .lit_o(lit));
   initial begin
      clk_i = 1'h0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; rd is taken at the edge that samples ack high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'h1);
      rd = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic blinks(input int b, input int n);
      c = 0;
      repeat (n) begin
         @(negedge clk_i);
         c += int'(lit[b]);
      end
   endtask
   task automatic pkt(input logic s, input logic e);
      @(posedge clk_i);
      tcrs <= 1'h1;
      seen <= s;
      err <= e;
      repeat (3) @(posedge clk_i);
      tcrs <= 1'h0;
      settle(3);
   endtask
   // Mid-run reset with a new select code, then count lit cycles.
   task automatic boot(input logic [2:0] s);
      @(posedge clk_i);
      rst_i <= 1'h1;
      sel <= s;
      pa <= '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'h0;
      blinks(10, 300);
   endtask
   function automatic logic [31:0] f_sel0(
      input rld_pkg::rld_port_attr_t [4:0] p);
      logic [31:0] e;
      e = 32'h0;
      e[5] = p[0].par;
      for (int i = 1; i < 5; i++) begin
         e[i] = p[i].link & ~p[i].par;
         e[i+5] = p[i].par;
      end
      return e;
   endfunction
   initial begin
      repeat (40000) @(posedge clk_i);
      bad_count++;
      stop_test();
   end
   initial begin
      seed = 68;
      {jabber_attr, act, tcrs, seen, err, rev, cyc, stb, we} = 9'h0;
      sel = 3'h0;
      be = 4'hF;
      pa = '0;
      adr = 8'h00;
      wdat = 32'h0;
      rst_i = 1'h1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(1'h0, 8'h04, 32'h0);
      cmp(rd, 32'h0);
      wb(1'h0, 8'h40, 32'h0);
      cmp(rd, 32'h0);
      repeat (20) begin
         @(posedge clk_i);
         r = $random(seed);
         pa <= r[24:0] & {5{5'h07}};
         jabber_attr <= r[31];
         settle(2);
         cmp({20'h0, lit[11:0]}, f_sel0(pa));
      end
      $display("mapping done");
      wb(1'h1, 8'h00, 32'h7);
      settle(2);
      cmp({26'h0, lit[10], lit[4:0]}, 32'h3F);
      wb(1'h1, 8'h00, 32'hC);
      settle(2);
      cmp({26'h0, lit[10], lit[4:0]}, 32'h0);
      wb(1'h1, 8'h00, 32'h9);
      settle(2);
      blinks(11, 64);
      cmp(c, 32'h20);
      wb(1'h1, 8'h00, 32'h0);
      be <= 4'hE;
      wb(1'h1, 8'h00, 32'h3);
      be <= 4'hF;
      wb(1'h0, 8'h00, 32'h0);
      cmp(rd, 32'h0);
      $display("override done");
      @(posedge clk_i);
      pa <= '0;
      pkt(1'h1, 1'h0);
      cmp({31'h0, lit[0]}, 32'h1);
      pkt(1'h1, 1'h1);
      cmp({31'h0, lit[0]}, 32'h0);
      pkt(1'h1, 1'h0);
      @(posedge clk_i);
      rev <= 1'h1;
      settle(2);
      cmp({31'h0, lit[0]}, 32'h0);
      @(posedge clk_i);
      rev <= 1'h0;
      pkt(1'h0, 1'h0);
      cmp({31'h0, lit[0]}, 32'h0);
      $display("loopback done");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_i);
         pa[3] <= (k == 0) ? 5'h10 : 5'h08;
         @(posedge clk_i);
         pa[3] <= 5'h00;
         settle(STR - 5);
         cmp({31'h0, lit[10+k]}, 32'h1);
         settle(10);
         cmp({31'h0, lit[10+k]}, 32'h0);
      end
      @(posedge clk_i);
      sel <= 3'h2;
      pa <= {5{5'h1F}};
      settle(3);
      cmp({20'h0, lit[11:0]}, 32'h0);
      @(posedge clk_i);
      sel <= 3'h6;
      pa <= {5'h00, 5'h14, 5'h02, 5'h04, 5'h00};
      // Let the carrier stretched by the previous step run out first.
      settle(STR + 3);
      cmp({28'h0, lit[7:6], lit[2:1]}, 32'hB);
      blinks(3, 32);
      cmp(c, 32'h10);
      $display("select done");
      @(posedge clk_i);
      act <= 1'h1;
      settle(2 * WIN + 5);
      cmp({24'h0, lit[19:12]}, 32'hFF);
      wb(1'h0, 8'h04, 32'h0);
      cmp({16'h0, rd[15:12], rd[7:0]}, 32'h6FF);
      @(posedge clk_i);
      act <= 1'h0;
      settle(2 * WIN + 5);
      cmp({24'h0, lit[19:12]}, 32'h0);
      $display("utilization done");
      // Sixteen blinks, each lit for half of a 260ms period.
      boot(3'h5);
      cmp(c, 32'h80);
      boot(3'h7);
      cmp(c, 32'h64);
      $display("power-up done");
      stop_test();
   end
endmodule
